// file: rtl/edge_catch_and_input_interrupt.sv
// Purpose: catch inputs, input interrupts with priority, queue and nesting guard
// Assumes: scan_end pulses once per scan from the scan sequencer; one clock
// Notes:   inputs bypass the debounce filter in catch mode; filter lives outside
//
// What this block does
// - catch mode latches a chosen edge per input, regardless of scan time
// - catch inputs bypass the debounce filter entirely
// - plain inputs update the input image only at end of scan
// - only the first caught edge in a scan counts
// - a catch flag stands exactly one scan then clears
// - interrupt mode fires on rising, falling or both edges
// - an interrupt vectors to that input's jump-target label
// - each group is interrupt, plain, counter or catch input
// - all five sources enabled at run; disable and enable instructions
// - one enable flag per input interrupt mirrors its state
// - calls from a routine nest at most 3; deeper flags error
// - five jump targets: four inputs then timer
// - simultaneous interrupts serve first input to fourth
// - interrupts during a routine wait until it ends
// - return resumes main program at the interrupted address
`timescale 1ns/1ps
module edge_catch_and_input_interrupt (
	input  wire logic                                  core_clk,
	input  wire logic                                  reset,
	input  wire logic [edge_irq_pkg::NUM_GROUPS-1:0]   dedicated_input,
	input  wire logic [edge_irq_pkg::NUM_GROUPS-1:0]   filtered_input,
	input  wire edge_irq_pkg::group_cfg_t              group_cfg [edge_irq_pkg::NUM_GROUPS],
	input  wire logic                                  running,
	input  wire logic                                  scan_end,
	input  wire logic                                  timer_tick,
	input  wire logic [edge_irq_pkg::LABEL_W-1:0]      irq_target_group1,
	input  wire logic [edge_irq_pkg::LABEL_W-1:0]      irq_target_group2,
	input  wire logic [edge_irq_pkg::LABEL_W-1:0]      irq_target_group3,
	input  wire logic [edge_irq_pkg::LABEL_W-1:0]      irq_target_group4,
	input  wire logic [edge_irq_pkg::LABEL_W-1:0]      timer_irq_target,
	input  wire logic [4:0]                            irq_disable_instr,
	input  wire logic [4:0]                            irq_enable_instr,
	input  wire logic                                  subroutine_call_instr,
	input  wire logic                                  subroutine_return_instr,
	input  wire logic [edge_irq_pkg::PC_W-1:0]         main_pc,
	output logic [edge_irq_pkg::NUM_GROUPS-1:0]        input_image,
	output logic [edge_irq_pkg::NUM_GROUPS-1:0]        counter_pulse,
	output logic                                       catch_flag_group1,
	output logic                                       catch_flag_group2,
	output logic                                       catch_flag_group3,
	output logic                                       catch_flag_group4,
	output logic                                       irq_enabled_group1,
	output logic                                       irq_enabled_group2,
	output logic                                       irq_enabled_group3,
	output logic                                       irq_enabled_group4,
	output logic                                       timer_irq_enabled,
	output edge_irq_pkg::vector_t                      vector,
	output logic                                       in_routine,
	output logic [edge_irq_pkg::PC_W-1:0]              resume_pc,
	output logic                                       resume_valid,
	output logic                                       user_exec_error_flag,
	output logic                                       error_led
);
	localparam int N = edge_irq_pkg::NUM_GROUPS;

	logic [N-1:0] level;
	logic [N-1:0] hit;

	// ==========================================================
	// per-group synchronise and edge detect
	for (genvar g = 0; g < N; g++) begin : g_edge
		edge_detect u_edge (
			.core_clk (core_clk),
			.reset    (reset),
			.pin      (dedicated_input[g]),
			.edge_sel (group_cfg[g].edge_sel),
			.level    (level[g]),
			.hit      (hit[g])
		);
	end

	function automatic logic [N-1:0] mode_mask(input edge_irq_pkg::group_func_t f_sel);
		logic [N-1:0] m;
		m = '0;
		for (int i = 0; i < N; i++) begin
			m[i] = (group_cfg[i].func == f_sel);
		end
		return m;
	endfunction : mode_mask

	logic [N-1:0] is_catch;
	logic [N-1:0] is_irq;
	logic [N-1:0] is_plain;
	logic [N-1:0] is_counter;
	// one function per group
	// always_comb, not assign: the masks must follow live changes of group_cfg
	always_comb begin
		is_catch   = mode_mask(edge_irq_pkg::FUNC_CATCH);
		is_irq     = mode_mask(edge_irq_pkg::FUNC_IRQ);
		is_plain   = mode_mask(edge_irq_pkg::FUNC_PLAIN);
		is_counter = mode_mask(edge_irq_pkg::FUNC_COUNTER);
	end
	assign counter_pulse = hit & is_counter;

	// ==========================================================
	// catch and input image
	logic [N-1:0] caught;
	logic [N-1:0] catch_flag;
	logic [N-1:0] image;
	logic [N-1:0] next_caught;
	logic [N-1:0] next_catch_flag;
	logic [N-1:0] next_image;

	always_comb begin
		next_caught     = caught;
		next_catch_flag = catch_flag;
		next_image      = image;
		// latch selected edge; raw path, filter unused
		for (int i = 0; i < N; i++) begin
			if (is_catch[i] && hit[i]) begin
				next_caught[i] = 1'b1;
			end
		end
		if (scan_end) begin
			// flag stands one scan, set wins over clear
			next_catch_flag = next_caught & is_catch;
			next_caught     = '0;
			// plain inputs sampled only at scan end
			for (int i = 0; i < N; i++) begin
				if (is_plain[i]) begin
					next_image[i] = filtered_input[i];
				end else if (is_catch[i]) begin
					next_image[i] = level[i];
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			caught     <= '0;
			catch_flag <= '0;
			image      <= '0;
		end else begin
			caught     <= next_caught;
			catch_flag <= next_catch_flag;
			image      <= next_image;
		end
	end

	assign input_image       = image;
	assign catch_flag_group1 = catch_flag[0];
	assign catch_flag_group2 = catch_flag[1];
	assign catch_flag_group3 = catch_flag[2];
	assign catch_flag_group4 = catch_flag[3];

	// no second flag within the scan
	catch_once_a: assert property (@(posedge core_clk) disable iff (reset)
		caught[0] && !scan_end |=> caught[0])
		else $error("catch latch dropped mid scan");
	// flag follows latch at scan end
	catch_scan_a: assert property (@(posedge core_clk) disable iff (reset)
		scan_end && caught[1] && is_catch[1] |=> catch_flag[1])
		else $error("catch flag not raised at scan end");
	catch_clear_a: assert property (@(posedge core_clk) disable iff (reset)
		scan_end && !caught[2] && !hit[2] |=> !catch_flag[2])
		else $error("catch flag not cleared after one scan");
	image_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		!scan_end |=> $stable(image))
		else $error("input image changed outside scan end");

	// ==========================================================
	// enables, pending, dispatch and nesting
	logic [4:0]                           enabled;
	logic [4:0]                           pending;
	logic                                 busy;
	logic [edge_irq_pkg::DEPTH_W-1:0]     depth;
	logic                                 err;
	edge_irq_pkg::vector_t                vec;
	logic [edge_irq_pkg::PC_W-1:0]        ret_pc;
	logic                                 ret_valid;
	logic [4:0]                           next_enabled;
	logic [4:0]                           next_pending;
	logic                                 next_busy;
	logic [edge_irq_pkg::DEPTH_W-1:0]     next_depth;
	logic                                 next_err;
	edge_irq_pkg::vector_t                next_vec;
	logic [edge_irq_pkg::PC_W-1:0]        next_ret_pc;
	logic                                 next_ret_valid;
	logic [4:0]                           raw_req;
	logic [edge_irq_pkg::LABEL_W-1:0]     targets [5];

	assign targets[0] = irq_target_group1;
	assign targets[1] = irq_target_group2;
	assign targets[2] = irq_target_group3;
	assign targets[3] = irq_target_group4;
	assign targets[4] = timer_irq_target;

	assign raw_req = {timer_tick, hit & is_irq};

	always_comb begin
		next_enabled   = enabled;
		next_pending   = pending;
		next_busy      = busy;
		next_depth     = depth;
		next_err       = err;
		next_vec       = vec;
		next_vec.valid = 1'b0;
		next_ret_pc    = ret_pc;
		next_ret_valid = 1'b0;
		next_enabled = (enabled & ~irq_disable_instr) | irq_enable_instr;
		if (!running) begin
			next_enabled = {edge_irq_pkg::TIMER_EN_RESET, edge_irq_pkg::ENABLE_RESET};
			next_pending = '0;
		end else begin
			next_pending = pending | (raw_req & enabled);
		end
		// nest limit on calls within a routine
		if (busy && subroutine_call_instr) begin
			if (depth == edge_irq_pkg::DEPTH_W'(edge_irq_pkg::NEST_MAX)) begin
				next_err = 1'b1;
			end else begin
				next_depth = depth + 1'b1;
			end
		end
		if (busy && subroutine_return_instr) begin
			if (depth != edge_irq_pkg::DEPTH_RESET) begin
				next_depth = depth - 1'b1;
			end else begin
				next_busy      = 1'b0;
				next_ret_valid = 1'b1;
			end
		end
		// dispatch only when idle; lowest index first
		if (!busy && running) begin
			for (int i = 4; i >= 0; i--) begin
				if (pending[i]) begin
					next_vec.valid       = 1'b1;
					next_vec.source      = 3'(i);
					next_vec.target      = targets[i];
					next_vec.return_addr = main_pc;
					next_ret_pc          = main_pc;
				end
			end
			if (|pending) begin
				next_busy = 1'b1;
				next_depth = edge_irq_pkg::DEPTH_RESET;
				for (int i = 0; i < 5; i++) begin
					if (pending[i] && (pending & ((5'h01 << i) - 5'h01)) == 5'h00) begin
						next_pending[i] = raw_req[i] & enabled[i];
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			enabled   <= {edge_irq_pkg::TIMER_EN_RESET, edge_irq_pkg::ENABLE_RESET};
			pending   <= '0;
			busy      <= 1'b0;
			depth     <= edge_irq_pkg::DEPTH_RESET;
			err       <= 1'b0;
			vec       <= '0;
			ret_pc    <= '0;
			ret_valid <= 1'b0;
		end else begin
			enabled   <= next_enabled;
			pending   <= next_pending;
			busy      <= next_busy;
			depth     <= next_depth;
			err       <= next_err;
			vec       <= next_vec;
			ret_pc    <= next_ret_pc;
			ret_valid <= next_ret_valid;
		end
	end

	assign irq_enabled_group1   = enabled[0];
	assign irq_enabled_group2   = enabled[1];
	assign irq_enabled_group3   = enabled[2];
	assign irq_enabled_group4   = enabled[3];
	assign timer_irq_enabled    = enabled[4];
	assign vector               = vec;
	assign in_routine           = busy;
	assign resume_pc            = ret_pc;
	assign resume_valid         = ret_valid;
	assign user_exec_error_flag = err;
	assign error_led            = err;

	prio_first_a: assert property (@(posedge core_clk) disable iff (reset)
		!busy && running && pending[0] |=> vec.valid && vec.source == 3'h0)
		else $error("priority order violated");
	no_overlap_a: assert property (@(posedge core_clk) disable iff (reset)
		busy |=> !vec.valid)
		else $error("dispatch while routine running");
	vector_label_a: assert property (@(posedge core_clk) disable iff (reset)
		!busy && running && pending[1] && !pending[0] |=> vec.target == $past(targets[1]))
		else $error("wrong jump target");
	nest_error_a: assert property (@(posedge core_clk) disable iff (reset)
		busy && subroutine_call_instr && depth == 2'h3 |=> err && error_led)
		else $error("nest overflow not flagged");
	disable_src_a: assert property (@(posedge core_clk) disable iff (reset)
		running && irq_disable_instr[2] && !irq_enable_instr[2] |=> !irq_enabled_group3)
		else $error("disable not applied");
	resume_addr_a: assert property (@(posedge core_clk) disable iff (reset)
		resume_valid |-> resume_pc == vec.return_addr)
		else $error("resume address mismatch");
endmodule : edge_catch_and_input_interrupt

// file: rtl/edge_detect.sv
// Purpose: two-stage synchroniser plus edge detection for one input group
// Assumes: pin is asynchronous to core_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module edge_detect (
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic                   pin,
	input  wire edge_irq_pkg::edge_sel_t edge_sel,
	output logic                        level,
	output logic                        hit
);
	logic meta;
	logic sync;
	logic prev;
	logic next_meta;
	logic next_sync;
	logic next_prev;
	logic [2:0] fill;
	logic [2:0] next_fill;

	// ==========================================================
	// synchroniser
	always_comb begin
		next_meta = pin;
		next_sync = meta;
		next_prev = sync;
		next_fill = {fill[1:0], 1'b1};
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
			fill <= 3'h0;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
			prev <= next_prev;
			fill <= next_fill;
		end
	end

	assign level = sync;

	// ==========================================================
	// edge select
	// no edge until the pipe is full: a pin idling high would look like a rise after reset
	always_comb begin
		hit = 1'b0;
		if (fill[2]) begin
			unique case (edge_sel)
				edge_irq_pkg::EDGE_RISE: hit = sync & ~prev;
				edge_irq_pkg::EDGE_FALL: hit = ~sync & prev;
				edge_irq_pkg::EDGE_BOTH: hit = sync ^ prev;
				default:                 hit = 1'b0;
			endcase
		end
	end
endmodule : edge_detect

// file: rtl/edge_irq_pkg.sv
// Purpose: shared constants and types for the edge catch and input interrupt block
// Assumes: four input groups, one timer source, 16-bit label numbers
// Notes:   all offsets, reset values and counts live here
package edge_irq_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_GROUPS  = 4;
	localparam int LABEL_W     = 16;
	localparam int PC_W        = 16;
	localparam int NEST_MAX    = 3;
	localparam int DEPTH_W     = 2;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// reset values
	localparam logic [NUM_GROUPS-1:0] ENABLE_RESET    = 4'hF;
	localparam logic                  TIMER_EN_RESET  = 1'h1;
	localparam logic [LABEL_W-1:0]    LABEL_RESET     = 16'h0000;
	localparam logic [DEPTH_W-1:0]    DEPTH_RESET     = 2'h0;

	// ==========================================================
	// source index of the timer in the target table
	localparam logic [2:0] TIMER_SRC = 3'h4;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		FUNC_IRQ,
		FUNC_PLAIN,
		FUNC_COUNTER,
		FUNC_CATCH
	} group_func_t;

	typedef enum logic [1:0] {
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} edge_sel_t;

	typedef struct packed {
		group_func_t func;
		edge_sel_t   edge_sel;
	} group_cfg_t;

	typedef struct packed {
		logic               valid;
		logic [2:0]         source;
		logic [LABEL_W-1:0] target;
		logic [PC_W-1:0]    return_addr;
	} vector_t;
endpackage : edge_irq_pkg

// file: test/edge_catch_and_input_interrupt_tb.sv
// Purpose: self-checking bench for catch inputs and input interrupts
// Assumes: sensor model drives the pins; bench plays the scan engine
// Notes:   vectors and resume addresses are checked from queues
`timescale 1ns/1ps
module edge_catch_and_input_interrupt_tb;
	`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
		$display("[ERR] %s expected %h seen %h", n, e, g); end end
	logic        core_clk, reset, running, scan_end, timer_tick;
	logic        subroutine_call_instr, subroutine_return_instr;
	logic [3:0]  filtered_input, idle_level, fire, busy, dedicated_input;
	logic [3:0]  input_image, counter_pulse;
	logic [15:0] irq_target_group1, irq_target_group2, irq_target_group3, irq_target_group4;
	logic [15:0] timer_irq_target, main_pc, resume_pc, epc;
	logic [4:0]  irq_disable_instr, irq_enable_instr;
	logic        catch_flag_group1, catch_flag_group2, catch_flag_group3, catch_flag_group4;
	logic        irq_enabled_group1, irq_enabled_group2, irq_enabled_group3, irq_enabled_group4;
	logic        timer_irq_enabled, in_routine, resume_valid, user_exec_error_flag, error_led;
	edge_irq_pkg::group_cfg_t group_cfg [edge_irq_pkg::NUM_GROUPS];
	edge_irq_pkg::vector_t    vector, ev;
	edge_irq_pkg::vector_t    exp_q [$];
	logic [15:0]              pc_q [$];
	int                       error_cnt, checks;
	integer                   seed;
	wire  [3:0]               flags = {catch_flag_group4, catch_flag_group3,
		catch_flag_group2, catch_flag_group1};
	wire  [4:0]               enables = {timer_irq_enabled, irq_enabled_group4,
		irq_enabled_group3, irq_enabled_group2, irq_enabled_group1};
	int                       pulse_cnt;

	sensor_model i_sensor (.core_clk, .idle_level, .fire, .pin(dedicated_input), .busy);
	edge_catch_and_input_interrupt i_dut (.core_clk, .reset, .dedicated_input, .filtered_input,
		.group_cfg, .running, .scan_end, .timer_tick, .irq_target_group1, .irq_target_group2,
		.irq_target_group3, .irq_target_group4, .timer_irq_target, .irq_disable_instr,
		.irq_enable_instr, .subroutine_call_instr, .subroutine_return_instr, .main_pc,
		.input_image, .counter_pulse, .catch_flag_group1, .catch_flag_group2,
		.catch_flag_group3, .catch_flag_group4, .irq_enabled_group1, .irq_enabled_group2,
		.irq_enabled_group3, .irq_enabled_group4, .timer_irq_enabled, .vector, .in_routine,
		.resume_pc, .resume_valid, .user_exec_error_flag, .error_led);

	// ==========================================================
	// clock and tasks
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : tick

	// one-cycle instruction strobes; the trailing gap keeps back-to-back calls apart
	task automatic strobe(input logic [4:0] dis, input logic [4:0] en, input logic [3:0] misc);
		irq_disable_instr = dis;
		irq_enable_instr = en;
		{timer_tick, scan_end, subroutine_call_instr, subroutine_return_instr} = misc;
		tick(1);
		irq_disable_instr = 5'h00;
		irq_enable_instr = 5'h00;
		{timer_tick, scan_end, subroutine_call_instr, subroutine_return_instr} = 4'h0;
		tick(1);
	endtask : strobe

	task automatic fire_wait(input logic [3:0] m);
		fire = m;
		tick(1);
		fire = 4'h0;
		for (int i = 0; i < 5000 && busy !== 4'h0; i++) tick(1);
	endtask : fire_wait

	task automatic expv(input logic [2:0] src, input logic [15:0] tgt);
		exp_q.push_back(edge_irq_pkg::vector_t'{1'b1, src, tgt, main_pc});
	endtask : expv

	task automatic serve();
		for (int i = 0; i < 50 && in_routine !== 1'b1; i++) tick(1);
		`CHK("in_routine", 1'b1, in_routine)
		pc_q.push_back(main_pc);
		strobe(5'h00, 5'h00, 4'h1);
		tick(3);
	endtask : serve

	task automatic results();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results

	// ==========================================================
	// result monitor
	always @(negedge core_clk) begin
		if (counter_pulse !== 4'h0) pulse_cnt++;
		if (vector.valid === 1'b1) begin
			ev = exp_q.size() ? exp_q.pop_front() : '0;
			`CHK("vector", ev, vector)
		end
		if (resume_valid === 1'b1) begin
			epc = pc_q.size() ? pc_q.pop_front() : 16'hXXXX;
			`CHK("resume_pc", epc, resume_pc)
		end
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		error_cnt++;
		$display("[ERR] watchdog expected done seen hang");
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 32'hABD03503;
		{reset, running, fire, filtered_input, idle_level} = {2'h3, 4'h0, 4'h0, 4'h2};
		{irq_disable_instr, irq_enable_instr, timer_tick, scan_end} = 12'h000;
		{subroutine_call_instr, subroutine_return_instr} = 2'h0;
		main_pc = 16'($random(seed));
		{irq_target_group1, irq_target_group2} = $random(seed);
		{irq_target_group3, irq_target_group4} = $random(seed);
		timer_irq_target = 16'($random(seed));
		group_cfg[0] = '{edge_irq_pkg::FUNC_CATCH, edge_irq_pkg::EDGE_RISE};
		group_cfg[1] = '{edge_irq_pkg::FUNC_CATCH, edge_irq_pkg::EDGE_FALL};
		group_cfg[2] = '{edge_irq_pkg::FUNC_PLAIN, edge_irq_pkg::EDGE_RISE};
		group_cfg[3] = '{edge_irq_pkg::FUNC_COUNTER, edge_irq_pkg::EDGE_RISE};
		tick(8);
		reset = 1'b0;
		tick(2);
		`CHK("enables", 5'h1F, enables)
		`CHK("catch reset", 4'h0, flags)
		$display("test reset done");
		fire_wait(4'hB);
		fire_wait(4'h1);
		filtered_input[2] = 1'b1;
		tick(4);
		`CHK("image held", 1'b0, input_image[2])
		strobe(5'h00, 5'h00, 4'h4);
		`CHK("catch set", 4'h3, flags)
		`CHK("image scan", 1'b1, input_image[2])
		filtered_input[1:0] = 2'($random(seed));
		tick(3);
		strobe(5'h00, 5'h00, 4'h4);
		`CHK("catch clear", 4'h0, flags)
		`CHK("filter bypass", 2'h2, input_image[1:0])
		`CHK("counter pulses", 1, pulse_cnt)
		$display("test catch done");

		reset = 1'b1;
		foreach (group_cfg[i]) group_cfg[i].func = edge_irq_pkg::FUNC_IRQ;
		group_cfg[2].edge_sel = edge_irq_pkg::EDGE_BOTH;
		tick(2);
		reset = 1'b0;
		tick(2);
		expv(3'h0, irq_target_group1);
		expv(3'h3, irq_target_group4);
		fire_wait(4'h9);
		serve();
		serve();
		expv(3'h1, irq_target_group2);
		fire_wait(4'h2);
		serve();
		expv(3'h2, irq_target_group3);
		expv(3'h2, irq_target_group3);
		fire_wait(4'h4);
		serve();
		serve();
		$display("test priority done");
		strobe(5'h05, 5'h00, 4'h0);
		`CHK("group1 off", 1'b0, irq_enabled_group1)
		`CHK("group3 off", 1'b0, irq_enabled_group3)
		fire_wait(4'h1);
		strobe(5'h00, 5'h05, 4'h0);
		`CHK("group1 on", 1'b1, irq_enabled_group1)
		strobe(5'h10, 5'h10, 4'h0);
		`CHK("enable wins", 1'b1, timer_irq_enabled)
		strobe(5'h10, 5'h00, 4'h0);
		`CHK("timer off", 1'b0, timer_irq_enabled)
		strobe(5'h00, 5'h00, 4'h8);
		running = 1'b0;
		tick(2);
		`CHK("stop enables", 5'h1F, enables)
		running = 1'b1;
		strobe(5'h00, 5'h10, 4'h0);
		$display("test enable done");
		expv(edge_irq_pkg::TIMER_SRC, timer_irq_target);
		strobe(5'h00, 5'h00, 4'h8);
		tick(4);
		repeat (3) strobe(5'h00, 5'h00, 4'h2);
		`CHK("nest ok", 1'b0, user_exec_error_flag)
		strobe(5'h00, 5'h00, 4'h2);
		`CHK("nest error", 2'h3, {user_exec_error_flag, error_led})
		repeat (3) strobe(5'h00, 5'h00, 4'h1);
		serve();
		tick(5);
		`CHK("left over", 0, exp_q.size() + pc_q.size())
		$display("test nesting done");
		results();
	end
endmodule : edge_catch_and_input_interrupt_tb

// file: test/sensor_model.sv
// Purpose: external sensor outputs feeding the four dedicated inputs
// Assumes: one pulse per fire request; idle level chosen per group
// Notes:   widths default to the slowest variant at a 50 ns clock
`timescale 1ns/1ps
module sensor_model #(
	parameter int ON_CYC  = 800,
	parameter int OFF_CYC = 3000
) (
	input  wire logic       core_clk,
	input  wire logic [3:0] idle_level,
	input  wire logic [3:0] fire,
	output logic      [3:0] pin,
	output logic      [3:0] busy
);
	// ==========================================================
	// pulse timing
	int cnt [4] = '{0, 0, 0, 0};

	always @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (cnt[i] == 0 && fire[i] === 1'b1) cnt[i] <= ON_CYC + OFF_CYC;
			else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
		end
	end

	// busy covers the off time too, so a new pulse never shortens it
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i]  = idle_level[i] ^ (cnt[i] > OFF_CYC);
			busy[i] = (cnt[i] != 0);
		end
	end
endmodule : sensor_model
